// ==== rtl/cvr_defines.vh ====
// Constants for the converter configuration and interrupt register bank.
// Assumes an 8-bit serial register port and a 7-bit register address.
// Behaviour
// R01: Reads return last written value of bits
// R02: Mode bit 7 selects three-wire data pin
// R03: Mode bit 6 selects least-significant-bit first
// R04: Host changes bit order in single-byte writes
// R05: Soft reset defaults all bits except mode
// R06: Soft reset holds until bit written 0
// R07: Echo clock and data receiver power-down bits
// R08: Sample clock receiver power-down bit
// R09: Converter bias power-down bit
// R10: Clock generator stop bit
// R11: Receiver delay controller clock runs when set
// R12: Phase tracker controller clock runs when set
// R13: Write-only register of six interrupt enables
// R14: Enable zero clears flag and blocks requests
// R15: Sync lost flag
// R16: Sync locked flag, zero while unlocked
// R17: Tracker lost flag
// R18: Tracker locked flag, zero while unlocked
// R19: Receiver lost flag
// R20: Receiver locked flag, zero while unlocked
// R21: Flag set only when enabled; sticky
// R22: Undefined bits ignore writes, read zero
`ifndef CVR_DEFINES_VH
`define CVR_DEFINES_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define CVR_ADDR_MODE 7'h00
`define CVR_ADDR_PWR 7'h01
`define CVR_ADDR_GATE 7'h02
`define CVR_ADDR_IRQ_EN 7'h03
`define CVR_ADDR_IRQ_REQ 7'h04

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CVR_MODE_DIR 7
`define CVR_MODE_LSB 6
`define CVR_MODE_SRST 5
`define CVR_PWR_ECHO 5
`define CVR_PWR_RCVR 4
`define CVR_PWR_SCLK 1
`define CVR_PWR_BIAS 0
`define CVR_GATE_CLKGEN 3
`define CVR_GATE_RCVR 1
`define CVR_GATE_TRK 0
`define CVR_IRQ_MSB 5
`define CVR_INS_RD 7
`define CVR_INS_AMSB 6

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CVR_RST_MODE 3'h0
`define CVR_RST_PWR 4'h0
`define CVR_RST_GATE 3'h0
`define CVR_RST_IRQ 6'h00
`define CVR_BIT_LAST 3'h7

`endif

// ==== rtl/cvr_regs.v ====
// Serial-port register bank: mode, power-down, clock gating, interrupt
// enables and request flags. Assumes lock status levels arrive on clk.
`timescale 1ns/1ps
`include "cvr_defines.vh"

module cvr_regs (
  input wire clk,
  input wire rst_n,
  input wire spi_cs_n,
  input wire spi_sclk,
  input wire spi_sdio_in,
  output wire spi_sdio_out,
  output wire spi_sdio_oe,
  output wire spi_sdo_out,
  output wire spi_sdo_oe,
  input wire sync_lock,
  input wire tracker_lock,
  input wire receiver_lock,
  output wire soft_reset_active,
  output wire echo_clock_off,
  output wire data_receiver_off,
  output wire sample_clock_receiver_off,
  output wire converter_bias_off,
  output wire clock_generator_off,
  output wire receiver_ctrl_clock_on,
  output wire phase_tracker_clock_on
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg cs_s1_reg, cs_s2_reg;
  reg sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  reg sdi_s1_reg, sdi_s2_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      sdi_s1_reg <= 1'b0;
      sdi_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg <= spi_cs_n;
      cs_s2_reg <= cs_s1_reg;
      sclk_s1_reg <= spi_sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      sdi_s1_reg <= spi_sdio_in;
      sdi_s2_reg <= sdi_s1_reg;
    end
  end

  wire active = ~cs_s2_reg;
  wire sclk_rise = active & sclk_s2_reg & ~sclk_s3_reg;
  wire sclk_fall = active & ~sclk_s2_reg & sclk_s3_reg;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg [2:0] mode_reg;
  reg [3:0] pwr_reg;
  reg [2:0] gate_reg;
  reg [5:0] irq_en_reg;
  reg [5:0] irq_flag_reg;

  wire three_wire = mode_reg[2];
  wire lsb_first = mode_reg[1];
  wire soft_rst = mode_reg[0];

  function [7:0] rd_mux;
    input [6:0] a;
    begin
      case (a)
        `CVR_ADDR_MODE: rd_mux = {mode_reg, 5'h00}; // R01 R22
        `CVR_ADDR_PWR: rd_mux = {2'h0, pwr_reg[3:2], 2'h0, pwr_reg[1:0]}; // R01 R22
        `CVR_ADDR_GATE: rd_mux = {4'h0, gate_reg[2], 1'b0, gate_reg[1:0]}; // R01 R22
        `CVR_ADDR_IRQ_REQ: rd_mux = {2'h0, irq_flag_reg};
        // Enables are write-only; unmapped addresses read zero
        default: rd_mux = 8'h00; // R13 R22
      endcase
    end
  endfunction

  // ----------------------------------------
  // Serial port engine
  // ----------------------------------------
  reg data_phase_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] rx_reg;
  reg read_reg;
  reg [6:0] addr_reg;
  reg [7:0] tx_reg;
  reg out_bit_reg;
  reg drive_reg;

  // Bit order follows the live mode bit, so a change takes effect on the
  // very next byte; a multi-byte change would corrupt the stream.
  wire [7:0] rx_new = lsb_first ? {sdi_s2_reg, rx_reg[7:1]} // R03
                                : {rx_reg[6:0], sdi_s2_reg};
  wire byte_done = sclk_rise & (bit_cnt_reg == `CVR_BIT_LAST);
  wire wr_fire = byte_done & data_phase_reg & ~read_reg;
  wire [6:0] addr_inc = addr_reg + 7'h01;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_phase_reg <= 1'b0;
      bit_cnt_reg <= 3'h0;
      rx_reg <= 8'h00;
      read_reg <= 1'b0;
      addr_reg <= 7'h00;
      tx_reg <= 8'h00;
      out_bit_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else if (!active) begin
      data_phase_reg <= 1'b0;
      bit_cnt_reg <= 3'h0;
      drive_reg <= 1'b0;
    end else begin
      if (sclk_rise) begin
        rx_reg <= rx_new;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
      if (byte_done) begin
        if (!data_phase_reg) begin
          data_phase_reg <= 1'b1;
          read_reg <= rx_new[`CVR_INS_RD];
          addr_reg <= rx_new[`CVR_INS_AMSB:0];
          drive_reg <= rx_new[`CVR_INS_RD];
          tx_reg <= rd_mux(rx_new[`CVR_INS_AMSB:0]);
        end else begin
          addr_reg <= addr_inc;
          tx_reg <= rd_mux(addr_inc);
        end
      end
      if (sclk_fall && drive_reg) begin
        out_bit_reg <= lsb_first ? tx_reg[bit_cnt_reg] // R03
                                 : tx_reg[`CVR_BIT_LAST - bit_cnt_reg];
      end
    end
  end

  assign spi_sdio_out = out_bit_reg;
  assign spi_sdio_oe = drive_reg & active & three_wire; // R02
  assign spi_sdo_out = out_bit_reg;
  assign spi_sdo_oe = drive_reg & active & ~three_wire; // R02

  // ----------------------------------------
  // Lock event detection
  // ----------------------------------------
  reg [2:0] lock_prev_reg;
  wire [2:0] lock_now = {sync_lock, tracker_lock, receiver_lock};
  wire [2:0] got_lock = lock_now & ~lock_prev_reg;
  wire [2:0] lost_lock = ~lock_now & lock_prev_reg;
  wire [5:0] events = {lost_lock[2], got_lock[2], lost_lock[1], got_lock[1],
                       lost_lock[0], got_lock[0]};
  // A lost edge withdraws the matching locked flag
  wire [5:0] unlock_clr = {1'b0, lost_lock[2], 1'b0, lost_lock[1],
                           1'b0, lost_lock[0]}; // R16 R18 R20

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_prev_reg <= 3'h0;
    end else begin
      lock_prev_reg <= lock_now;
    end
  end

  // ----------------------------------------
  // Register updates
  // ----------------------------------------
  wire en_wr = wr_fire & (addr_reg == `CVR_ADDR_IRQ_EN);
  wire [5:0] irq_en_next = en_wr ? rx_new[`CVR_IRQ_MSB:0] : irq_en_reg; // R13
  wire [5:0] irq_flag_next = ((irq_flag_reg & ~unlock_clr) | (events & irq_en_reg))
                             & irq_en_next; // R14 R15 R17 R19 R21

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `CVR_RST_MODE;
    end else if (wr_fire && addr_reg == `CVR_ADDR_MODE) begin
      // Mode survives its own soft reset
      mode_reg <= {rx_new[`CVR_MODE_DIR], rx_new[`CVR_MODE_LSB],
                   rx_new[`CVR_MODE_SRST]}; // R02 R03 R05 R06
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg <= `CVR_RST_PWR;
      gate_reg <= `CVR_RST_GATE;
      irq_en_reg <= `CVR_RST_IRQ;
      irq_flag_reg <= `CVR_RST_IRQ;
    end else if (soft_rst) begin
      // Held at defaults for as long as the soft reset bit stays set
      pwr_reg <= `CVR_RST_PWR; // R05 R06
      gate_reg <= `CVR_RST_GATE;
      irq_en_reg <= `CVR_RST_IRQ;
      irq_flag_reg <= `CVR_RST_IRQ;
    end else begin
      if (wr_fire && addr_reg == `CVR_ADDR_PWR) begin
        pwr_reg <= {rx_new[`CVR_PWR_ECHO], rx_new[`CVR_PWR_RCVR],
                    rx_new[`CVR_PWR_SCLK], rx_new[`CVR_PWR_BIAS]}; // R07 R08 R09
      end
      if (wr_fire && addr_reg == `CVR_ADDR_GATE) begin
        gate_reg <= {rx_new[`CVR_GATE_CLKGEN], rx_new[`CVR_GATE_RCVR],
                     rx_new[`CVR_GATE_TRK]}; // R10 R11 R12
      end
      irq_en_reg <= irq_en_next; // R14
      irq_flag_reg <= irq_flag_next; // R21
    end
  end

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  assign soft_reset_active = soft_rst; // R06
  assign echo_clock_off = pwr_reg[3]; // R07
  assign data_receiver_off = pwr_reg[2]; // R07
  assign sample_clock_receiver_off = pwr_reg[1]; // R08
  assign converter_bias_off = pwr_reg[0]; // R09
  assign clock_generator_off = gate_reg[2]; // R10
  assign receiver_ctrl_clock_on = gate_reg[1]; // R11
  assign phase_tracker_clock_on = gate_reg[0]; // R12

endmodule

// ==== sim/cvr_regs_sva.sv ====
// Pin checker for the configuration register bank.
// Assumes it is bound into cvr_regs and sees only that module's pins.
`timescale 1ns/1ps
module cvr_regs_sva (
  input wire clk,
  input wire rst_n,
  input wire spi_cs_n,
  input wire spi_sdio_out,
  input wire spi_sdio_oe,
  input wire spi_sdo_out,
  input wire spi_sdo_oe,
  input wire soft_reset_active,
  input wire echo_clock_off,
  input wire converter_bias_off,
  input wire clock_generator_off,
  input wire phase_tracker_clock_on
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_oe_one; !(spi_sdio_oe && spi_sdo_oe); endproperty
  a_oe_one: assert property (p_oe_one) else $error("both data pins driven");
  property p_oe_off; spi_cs_n [*4] |-> !spi_sdio_oe && !spi_sdo_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("data pin driven while idle");
  property p_oe_rise; $rose(spi_sdo_oe) || $rose(spi_sdio_oe) |-> $past(!spi_cs_n, 3); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive without select");
  property p_pin_same; spi_sdo_oe |-> spi_sdo_out == spi_sdio_out; endproperty
  a_pin_same: assert property (p_pin_same) else $error("read pins disagree");
  property p_srst_pwr; soft_reset_active |=> !echo_clock_off && !converter_bias_off; endproperty
  a_srst_pwr: assert property (p_srst_pwr) else $error("power bits kept in soft reset");
  property p_srst_gate;
    soft_reset_active |=> !clock_generator_off && !phase_tracker_clock_on;
  endproperty
  a_srst_gate: assert property (p_srst_gate) else $error("gate bits kept in soft reset");
  property p_idle_hold;
    spi_cs_n [*6] ##0 !soft_reset_active |=> $stable(echo_clock_off) && $stable(clock_generator_off);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("register moved while idle");
  property p_srst_hold; spi_cs_n [*6] |=> $stable(soft_reset_active); endproperty
  a_srst_hold: assert property (p_srst_hold) else $error("soft reset moved while idle");
  c_rd4: cover property ($rose(spi_sdo_oe));
  c_rd3: cover property ($rose(spi_sdio_oe));
  c_srst: cover property ($rose(soft_reset_active));
endmodule

bind cvr_regs cvr_regs_sva i_sva (.*);

// ==== sim/cvr_host.sv ====
// Serial host model: one instruction byte and one data byte per frame.
// Assumes mode 0 with an 80 ns serial clock, idle low between frames.
`timescale 1ns/1ps
module cvr_host (
  input wire clk,
  input wire sdio_w,
  input wire sdo_w,
  output logic cs_n,
  output logic sclk,
  output logic d
);
  // ----------------------------------------
  // Frame task
  // ----------------------------------------
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    d = 1'b0;
  end
  // Single data byte per frame keeps a bit order change safe
  task automatic xfer(input logic [7:0] ins, input logic [7:0] dat, input logic lsb,
                      input logic tw, output logic [7:0] rx);
    int p;
    @(posedge clk);
    #1 cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      p = lsb ? i % 8 : 7 - i % 8;
      // Released line toggles so stale values never pass
      d = (ins[7] && i > 7) ? ~d : (i < 8 ? ins[p] : dat[p]);
      #40 sclk = 1'b1;
      if (i > 7) rx[p] = tw ? sdio_w : sdo_w;
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    #80;
  endtask
endmodule

// ==== sim/tb.sv ====
// Self-checking bench of the register bank against a mirror model.
// Assumes cvr_host drives the serial pins and lock levels come from here.
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // Mirror model and checks
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] lock = 3'h0;
  logic [31:0] lfsr = 32'hdd49c46f;
  logic [7:0] rx;
  int m[0:4] = '{default: 0};
  int n_mismatch = 0;
  int compares = 0;
  wire cs_n, sclk, hd, sdio_out, sdio_oe, sdo_out, sdo_oe, srst;
  wire [3:0] pw;
  wire [2:0] gt;
  wire sdio_w = sdio_oe ? sdio_out : hd;
  wire sdo_w = sdo_oe ? sdo_out : 1'bz;
  always #2 clk = ~clk;
  cvr_regs i_dut (.clk(clk), .rst_n(rst_n), .spi_cs_n(cs_n), .spi_sclk(sclk),
    .spi_sdio_in(sdio_w), .spi_sdio_out(sdio_out), .spi_sdio_oe(sdio_oe),
    .spi_sdo_out(sdo_out), .spi_sdo_oe(sdo_oe), .sync_lock(lock[2]),
    .tracker_lock(lock[1]), .receiver_lock(lock[0]), .soft_reset_active(srst),
    .echo_clock_off(pw[3]), .data_receiver_off(pw[2]), .sample_clock_receiver_off(pw[1]),
    .converter_bias_off(pw[0]), .clock_generator_off(gt[2]),
    .receiver_ctrl_clock_on(gt[1]), .phase_tracker_clock_on(gt[0]));
  cvr_host i_host (.clk(clk), .sdio_w(sdio_w), .sdo_w(sdo_w), .cs_n(cs_n), .sclk(sclk), .d(hd));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input int a, input logic [7:0] v);
    i_host.xfer(a[7:0], v, m[0][6], m[0][7], rx);
    if (a == 0) m[0] = v & 8'he0;
    else if (!m[0][5] && a < 4) begin
      m[a] = v & (a == 1 ? 8'h33 : a == 2 ? 8'h0b : 8'h3f);
      if (a == 3) m[4] &= v;
    end
    if (m[0][5]) for (int i = 1; i < 5; i++) m[i] = 0;
    chk("power pins", {2'h0, pw[3:2], 2'h0, pw[1:0]}, 8'(m[1]));
    chk("gate pins", {4'h0, gt[2], 1'b0, gt[1:0]}, 8'(m[2]));
    chk("soft reset pin", {7'h0, srst}, 8'(m[0] >> 5 & 1));
  endtask
  task automatic rd(input int a);
    i_host.xfer(8'h80 | a[7:0], 8'h00, m[0][6], m[0][7], rx);
    chk("read data", rx, (a == 3 || a > 4) ? 8'h00 : 8'(m[a % 5]));
  endtask
  task automatic lk(input int i, input logic v);
    @(posedge clk);
    #1 lock[i] = v;
    if (v && m[3][2*i]) m[4] |= 1 << 2 * i;
    if (!v) m[4] &= ~(1 << 2 * i);
    if (!v && m[3][2*i+1]) m[4] |= 2 << 2 * i;
  endtask
  initial begin
    // About twice the expected run, well under the cycle budget
    #200000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    for (int a = 0; a < 6; a++) rd(a);
    rd(127);
    repeat (4) begin
      wr(1, rnd());
      wr(2, rnd());
      rd(1);
      rd(2);
      wr(3, rnd());
      rd(3);
      wr(4, rnd());
      rd(4);
    end
    wr(3, 8'h3f);
    for (int i = 0; i < 3; i++) lk(i, 1'b1);
    rd(4);
    lk(1, 1'b0);
    rd(4);
    wr(3, 8'h3e);
    lk(0, 1'b0);
    rd(4);
    lk(1, 1'b1);
    lk(2, 1'b0);
    rd(4);
    wr(3, 8'h00);
    lk(0, 1'b1);
    rd(4);
    wr(0, 8'h80);
    rd(1);
    wr(0, 8'hc0);
    wr(1, rnd());
    rd(1);
    wr(0, 8'h20);
    rd(0);
    wr(1, 8'h33);
    rd(1);
    wr(0, 8'h00);
    wr(1, 8'h11);
    rd(1);
    // Mid-run hard reset must clear the mode and power registers again
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 5; i++) m[i] = 0;
    repeat (4) @(posedge clk);
    chk("power pins after reset", {2'h0, pw[3:2], 2'h0, pw[1:0]}, 8'h00);
    rd(0);
    rd(1);
    give_verdict();
  end
endmodule
